/* File: design/scint_pkg.sv */
// Constants, types and character codes for the service console interpreter
// What this block does
// - Only octal digits, the command letters and / . + @ CR LF form commands; others are errors.
// - Octal number then slash opens that 17-bit memory address; zeros optional.
// - Cell command with octal operand opens that internal register cell.
// - Step command closes current cell, opens next consecutive address or number.
// - Close command closes current cell and leaves none open.
// - Indirect command opens memory cell addressed by current cell's value.
// - Number then CR/LF/NL writes open cell; CR also opens next cell.
// - P resumes execution at the address held in internal cell 4.
// - nR issues I/O reset, clears map unit, starts execution at n.
// - I issues I/O reset and clears map unit, no execution start.
// - nL loads program from device n; bit 15 set means high speed.
// - F starts a bootstrap load from the service cassette device.
// - K discards the typed line and prints question mark, new line.
// - Unrecognised character prints question mark followed by new line.
// - Absent memory reads print all ones; writes there still read ones.
// - Unassigned internal cell numbers may return arbitrary data, no error.
// - Opening any cell prints its contents in octal.
// - Cells 0-3 accumulators, 4 return, 5 stack, 6 frame, 7 IE, 11 switches, 12 carry.
// - Entering console prints the low 16 bits of the saved program counter in octal and a ! prompt.
package scint_pkg;
   localparam int ADDR_W = 17;
   localparam int WORD_W = 16;
   localparam int CELL_W = 4;
   localparam int CHAR_W = 8;

   // Internal cell numbers
   localparam logic [CELL_W-1:0] CELL_RETURN = 4'h4;

   // Character codes
   localparam logic [7:0] CH_0     = 8'h30;
   localparam logic [7:0] CH_7     = 8'h37;
   localparam logic [7:0] CH_SLASH = 8'h2F;
   localparam logic [7:0] CH_CR    = 8'h0D;
   localparam logic [7:0] CH_LF    = 8'h0A;
   localparam logic [7:0] CH_SP    = 8'h20;
   localparam logic [7:0] CH_BANG  = 8'h21;
   localparam logic [7:0] CH_QUERY = 8'h3F;
   localparam logic [7:0] CH_P     = 8'h50;
   localparam logic [7:0] CH_R     = 8'h52;
   localparam logic [7:0] CH_I     = 8'h49;
   localparam logic [7:0] CH_L     = 8'h4C;
   localparam logic [7:0] CH_F     = 8'h46;
   localparam logic [7:0] CH_K     = 8'h4B;
   localparam logic [7:0] CH_CELL  = 8'h41;
   localparam logic [7:0] CH_CLOSE = 8'h2E;
   localparam logic [7:0] CH_STEP  = 8'h2B;
   localparam logic [7:0] CH_IND   = 8'h40;

   // Message kinds and their last index
   typedef enum logic [1:0] {PK_VALUE, PK_ERROR, PK_PROMPT, PK_ENTRY} scint_pkind_t;
   localparam logic [3:0] LAST_VALUE  = 4'h6;
   localparam logic [3:0] LAST_ERROR  = 4'h3;
   localparam logic [3:0] LAST_PROMPT = 4'h2;
   localparam logic [3:0] LAST_ENTRY  = 4'hA;
   localparam logic [WORD_W-1:0] WORD_ONES = 16'hFFFF;

   // Memory request towards the CPU memory port
   typedef struct packed {
      logic              req;
      logic              we;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] wdata;
   } scint_mem_t;

   // One-cycle control pulses towards the CPU, with their operands, which hold until the next command
   typedef struct packed {
      logic              io_reset;
      logic              map_clear;
      logic              run_start;
      logic [ADDR_W-1:0] run_addr;
      logic              load_start;
      logic [WORD_W-1:0] load_dev;
      logic              load_high;
      logic              boot_start;
   } scint_ctl_t;
endpackage

/* File: design/scint_top.sv */
// Service console interpreter: command decode, cell access and octal printing
`timescale 1ns/100ps
`default_nettype none
module scint_top #(
   parameter logic [7:0] CELL_CH  = scint_pkg::CH_CELL,
   parameter logic [7:0] CLOSE_CH = scint_pkg::CH_CLOSE,
   parameter logic [7:0] STEP_CH  = scint_pkg::CH_STEP,
   parameter logic [7:0] IND_CH   = scint_pkg::CH_IND
) (
   // Clock and reset
   input  wire logic                          core_clk_in,
   input  wire logic                          rst_n_in,
   // Terminal receive side
   input  wire logic                          rx_valid_in,
   input  wire logic [scint_pkg::CHAR_W-1:0]  rx_data_in,
   output var  logic                          rx_ready_out,
   // Terminal transmit side
   output var  logic                          tx_valid_out,
   output var  logic [scint_pkg::CHAR_W-1:0]  tx_data_out,
   input  wire logic                          tx_ready_in,
   // Memory port
   output var  scint_pkg::scint_mem_t         mem_out,
   input  wire logic                          mem_ack_in,
   input  wire logic                          mem_present_in,
   input  wire logic [scint_pkg::WORD_W-1:0]  mem_rdata_in,
   // Internal cell port
   output var  logic [scint_pkg::CELL_W-1:0]  cell_sel_out,
   output var  logic                          cell_we_out,
   output var  logic [scint_pkg::WORD_W-1:0]  cell_wdata_out,
   input  wire logic [scint_pkg::WORD_W-1:0]  cell_rdata_in,
   // CPU control
   input  wire logic                          enter_in,
   input  wire logic [scint_pkg::ADDR_W-1:0]  enter_pc_in,
   output var  scint_pkg::scint_ctl_t         ctl_out,
   output var  logic                          console_active_out
);
   import scint_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_MEM_RD, ST_CELL_RD, ST_MEM_WR, ST_RUN_RD, ST_PRINT
   } scint_state_t;

   scint_state_t      state;
   scint_pkind_t      pkind;
   logic [3:0]        pidx;
   logic [WORD_W-1:0] pval;
   logic [ADDR_W-1:0] num;
   logic              have_num;
   logic              is_open;
   logic              open_mem;
   logic [ADDR_W-1:0] cur_addr;
   logic [WORD_W-1:0] cur_val;
   logic              pend_step;

   // One octal digit of a six-digit word print, leftmost first
   function automatic logic [7:0] octal_char(input logic [3:0] k, input logic [WORD_W-1:0] v);
      logic [2:0] d;
      d = 3'h0;
      case (k)
         4'h0:    d = {2'h0, v[15]};
         4'h1:    d = v[14:12];
         4'h2:    d = v[11:9];
         4'h3:    d = v[8:6];
         4'h4:    d = v[5:3];
         default: d = v[2:0];
      endcase
      return CH_0 + {5'h00, d};
   endfunction

   // Character at a message position plus a last-character flag
   function automatic logic [8:0] msg_char(input scint_pkind_t k, input logic [3:0] i,
                                           input logic [WORD_W-1:0] v);
      logic [7:0] c;
      c = CH_SP;
      unique case (k)
         PK_VALUE:  c = (i < LAST_VALUE) ? octal_char(i, v) : CH_SP;
         PK_ERROR:  c = (i == 4'h0) ? CH_QUERY : (i == 4'h1) ? CH_CR :
                        (i == 4'h2) ? CH_LF : CH_BANG;
         PK_PROMPT: c = (i == 4'h0) ? CH_CR : (i == 4'h1) ? CH_LF : CH_BANG;
         PK_ENTRY:  c = (i == 4'h0) ? CH_CR : (i == 4'h1) ? CH_LF :
                        (i < 4'h8) ? octal_char(i - 4'h2, v) :
                        (i == 4'h8) ? CH_CR : (i == 4'h9) ? CH_LF : CH_BANG;
      endcase
      return {(i == msg_last(k)), c};
   endfunction

   function automatic logic [3:0] msg_last(input scint_pkind_t k);
      logic [3:0] l;
      l = LAST_VALUE;
      unique case (k)
         PK_VALUE:  l = LAST_VALUE;
         PK_ERROR:  l = LAST_ERROR;
         PK_PROMPT: l = LAST_PROMPT;
         PK_ENTRY:  l = LAST_ENTRY;
      endcase
      return l;
   endfunction

   // Input character classification
   wire       accept    = rx_valid_in && rx_ready_out && (state == ST_IDLE);
   wire [7:0] ch        = rx_data_in;
   wire       is_digit  = (ch >= CH_0) && (ch <= CH_7);
   wire [2:0] digit_val = ch[2:0];
   wire       is_eol    = (ch == CH_CR) || (ch == CH_LF);
   wire [ADDR_W-1:0] num_shift = {num[ADDR_W-4:0], digit_val};
   wire [ADDR_W-1:0] step_addr = open_mem ? cur_addr + 17'h00001 :
                                 {13'h0000, cur_addr[CELL_W-1:0] + 4'h1};
   wire [ADDR_W-1:0] ind_addr  = {1'b0, cur_val};
   wire [WORD_W-1:0] mem_word  = mem_present_in ? mem_rdata_in : WORD_ONES;
   wire [8:0]        pchar     = msg_char(pkind, pidx, pval);
   wire              tx_free   = !tx_valid_out || tx_ready_in;

   // Terminal receive handshake, at most one character per two cycles while idle
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_ready_out <= 1'b0;
      end else begin
         rx_ready_out <= (state == ST_IDLE) && !accept && console_active_out;
      end
   end

   // Main interpreter sequence
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state              <= ST_PRINT;
         pkind              <= PK_ENTRY;
         pidx               <= 4'h0;
         pval               <= 16'h0000;
         num                <= 17'h00000;
         have_num           <= 1'b0;
         is_open            <= 1'b0;
         open_mem           <= 1'b0;
         cur_addr           <= 17'h00000;
         cur_val            <= 16'h0000;
         pend_step          <= 1'b0;
         tx_valid_out       <= 1'b0;
         tx_data_out        <= 8'h00;
         mem_out            <= '0;
         cell_sel_out       <= 4'h0;
         cell_we_out        <= 1'b0;
         cell_wdata_out     <= 16'h0000;
         ctl_out            <= '0;
         console_active_out <= 1'b1;
      end else begin
         ctl_out.io_reset   <= 1'b0;
         ctl_out.map_clear  <= 1'b0;
         ctl_out.run_start  <= 1'b0;
         ctl_out.load_start <= 1'b0;
         ctl_out.boot_start <= 1'b0;
         cell_we_out        <= 1'b0;
         if (tx_valid_out && tx_ready_in) begin
            tx_valid_out <= 1'b0;
         end
         if (enter_in && !console_active_out) begin
            console_active_out <= 1'b1;
            is_open            <= 1'b0;
            have_num           <= 1'b0;
            num                <= 17'h00000;
            pkind              <= PK_ENTRY;
            pidx               <= 4'h0;
            pval               <= enter_pc_in[WORD_W-1:0];
            state              <= ST_PRINT;
         end else begin
            unique case (state)
               ST_IDLE: begin
                  if (accept) begin
                     have_num <= 1'b0;
                     num      <= 17'h00000;
                     if (is_digit) begin
                        num      <= num_shift;
                        have_num <= 1'b1;
                     end else if (ch == CH_SLASH && have_num) begin
                        open_mem <= 1'b1;
                        cur_addr <= num;
                        mem_out  <= '{req: 1'b1, we: 1'b0, addr: num, wdata: 16'h0000};
                        state    <= ST_MEM_RD;
                     end else if (ch == CELL_CH && have_num) begin
                        open_mem     <= 1'b0;
                        cur_addr     <= num;
                        cell_sel_out <= num[CELL_W-1:0];
                        state        <= ST_CELL_RD;
                     end else if (ch == STEP_CH && is_open && !have_num) begin
                        cur_addr <= step_addr;
                        if (open_mem) begin
                           mem_out <= '{req: 1'b1, we: 1'b0, addr: step_addr,
                                        wdata: 16'h0000};
                           state   <= ST_MEM_RD;
                        end else begin
                           cell_sel_out <= step_addr[CELL_W-1:0];
                           state        <= ST_CELL_RD;
                        end
                     end else if (ch == CLOSE_CH && !have_num) begin
                        is_open <= 1'b0;
                        pkind   <= PK_PROMPT;
                        pidx    <= 4'h0;
                        state   <= ST_PRINT;
                     end else if (ch == IND_CH && is_open && !have_num) begin
                        open_mem <= 1'b1;
                        cur_addr <= ind_addr;
                        mem_out  <= '{req: 1'b1, we: 1'b0, addr: ind_addr,
                                      wdata: 16'h0000};
                        state    <= ST_MEM_RD;
                     end else if (is_eol && is_open) begin
                        pend_step <= (ch == CH_CR);
                        if (have_num && open_mem) begin
                           mem_out <= '{req: 1'b1, we: 1'b1, addr: cur_addr,
                                        wdata: num[WORD_W-1:0]};
                           state   <= ST_MEM_WR;
                        end else begin
                           if (have_num) begin
                              cell_we_out    <= 1'b1;
                              cell_sel_out   <= cur_addr[CELL_W-1:0];
                              cell_wdata_out <= num[WORD_W-1:0];
                           end
                           state <= ST_MEM_WR;
                        end
                     end else if (is_eol && !have_num) begin
                        pkind <= PK_PROMPT;
                        pidx  <= 4'h0;
                        state <= ST_PRINT;
                     end else if (ch == CH_P && !have_num) begin
                        cell_sel_out <= CELL_RETURN;
                        state        <= ST_RUN_RD;
                     end else if (ch == CH_R && have_num) begin
                        ctl_out.io_reset   <= 1'b1;
                        ctl_out.map_clear  <= 1'b1;
                        ctl_out.run_start  <= 1'b1;
                        ctl_out.run_addr   <= num;
                        console_active_out <= 1'b0;
                        is_open            <= 1'b0;
                     end else if (ch == CH_I && !have_num) begin
                        ctl_out.io_reset  <= 1'b1;
                        ctl_out.map_clear <= 1'b1;
                        pkind             <= PK_PROMPT;
                        pidx              <= 4'h0;
                        state             <= ST_PRINT;
                     end else if (ch == CH_L && have_num) begin
                        ctl_out.load_start <= 1'b1;
                        ctl_out.load_dev   <= num[WORD_W-1:0];
                        ctl_out.load_high  <= num[WORD_W-1];
                        console_active_out <= 1'b0;
                        is_open            <= 1'b0;
                     end else if (ch == CH_F && !have_num) begin
                        ctl_out.boot_start <= 1'b1;
                        console_active_out <= 1'b0;
                        is_open            <= 1'b0;
                     end else begin
                        pkind <= PK_ERROR;
                        pidx  <= 4'h0;
                        state <= ST_PRINT;
                     end
                  end
               end
               ST_MEM_RD: begin
                  if (mem_ack_in) begin
                     mem_out.req <= 1'b0;
                     is_open     <= 1'b1;
                     cur_val     <= mem_word;
                     pval        <= mem_word;
                     pkind       <= PK_VALUE;
                     pidx        <= 4'h0;
                     state       <= ST_PRINT;
                  end
               end
               ST_CELL_RD: begin
                  is_open <= 1'b1;
                  cur_val <= cell_rdata_in;
                  pval    <= cell_rdata_in;
                  pkind   <= PK_VALUE;
                  pidx    <= 4'h0;
                  state   <= ST_PRINT;
               end
               ST_MEM_WR: begin
                  if (mem_out.req) begin
                     if (mem_ack_in) begin
                        mem_out.req <= 1'b0;                               // Idle a cycle before reading on
                     end
                  end else begin
                     if (pend_step) begin
                        cur_addr <= step_addr;
                        if (open_mem) begin
                           mem_out <= '{req: 1'b1, we: 1'b0, addr: step_addr,
                                        wdata: 16'h0000};
                           state   <= ST_MEM_RD;
                        end else begin
                           cell_sel_out <= step_addr[CELL_W-1:0];
                           state        <= ST_CELL_RD;
                        end
                     end else begin
                        is_open <= 1'b0;
                        pkind   <= PK_PROMPT;
                        pidx    <= 4'h0;
                        state   <= ST_PRINT;
                     end
                  end
               end
               ST_RUN_RD: begin
                  ctl_out.run_start  <= 1'b1;
                  ctl_out.run_addr   <= {1'b0, cell_rdata_in};
                  console_active_out <= 1'b0;
                  is_open            <= 1'b0;
                  state              <= ST_IDLE;
               end
               ST_PRINT: begin
                  if (tx_free) begin
                     tx_valid_out <= 1'b1;
                     tx_data_out  <= pchar[7:0];
                     if (pchar[8]) begin
                        state <= ST_IDLE;
                     end else begin
                        pidx <= pidx + 4'h1;
                     end
                  end
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* File: bench/scint_chk.sv */
// Port-level assertions for the service console interpreter
`timescale 1ns/100ps
`default_nettype none
module scint_chk (
   // Clock and reset
   input  wire logic                          core_clk_in,
   input  wire logic                          rst_n_in,
   // Observed ports
   input  wire logic                          tx_valid_out,
   input  wire logic [scint_pkg::CHAR_W-1:0]  tx_data_out,
   input  wire logic                          tx_ready_in,
   input  wire scint_pkg::scint_mem_t         mem_out,
   input  wire logic                          mem_ack_in,
   input  wire logic [scint_pkg::CELL_W-1:0]  cell_sel_out,
   input  wire logic                          cell_we_out,
   input  wire logic [scint_pkg::WORD_W-1:0]  cell_rdata_in,
   input  wire scint_pkg::scint_ctl_t         ctl_out,
   input  wire logic                          console_active_out
);
   import scint_pkg::*;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   // Handshakes hold until answered
   AST_TX_HOLD: assert property (tx_valid_out && !tx_ready_in |=>
      tx_valid_out && $stable(tx_data_out)) else $error("printed char not held");
   AST_MEM_HOLD: assert property (mem_out.req && !mem_ack_in |=>
      mem_out.req && $stable(mem_out)) else $error("memory request not held");
   AST_MEM_DROP: assert property (mem_out.req && mem_ack_in |=> !mem_out.req)
      else $error("memory request kept after ack");
   // Control pulses and their companions
   AST_RESET_MAP: assert property (ctl_out.io_reset |->
      ctl_out.map_clear && !ctl_out.load_start) else $error("io reset without map clear");
   AST_RUN_PULSE: assert property (ctl_out.run_start |=> !ctl_out.run_start)
      else $error("run start longer than one cycle");
   AST_LOAD_SPEED: assert property (ctl_out.load_start |->
      ctl_out.load_high == ctl_out.load_dev[15]) else $error("load speed bit wrong");
   AST_LEAVE: assert property (ctl_out.run_start || ctl_out.load_start ||
      ctl_out.boot_start |=> !console_active_out) else $error("console stayed active");
   AST_RESUME: assert property (ctl_out.run_start && !ctl_out.io_reset |->
      $past(cell_sel_out) == CELL_RETURN && ctl_out.run_addr == {1'h0, $past(cell_rdata_in)})
      else $error("resume address not from return cell");
   AST_CELL_WE: assert property (cell_we_out |=> !cell_we_out)
      else $error("cell write longer than one cycle");
endmodule
bind scint_top scint_chk chk_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
   .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in),
   .mem_out(mem_out), .mem_ack_in(mem_ack_in), .cell_sel_out(cell_sel_out),
   .cell_we_out(cell_we_out), .cell_rdata_in(cell_rdata_in), .ctl_out(ctl_out),
   .console_active_out(console_active_out));
`default_nettype wire

/* File: bench/scint_term.sv */
// Terminal model: types characters and collects printed ones
`timescale 1ns/100ps
`default_nettype none
module scint_term (
   // Clock
   input  wire logic        clk_in,
   // Keyboard side
   output var  logic        rx_valid_out,
   output var  logic [7:0]  rx_data_out,
   input  wire logic        rx_ready_in,
   // Printer side
   input  wire logic        tx_valid_in,
   input  wire logic [7:0]  tx_data_in,
   output var  logic        tx_ready_out
);
   logic       slow = 1'h0;
   logic [7:0] got[$];
   initial rx_valid_out = 1'h0;
   initial rx_data_out = 8'h00;
   initial tx_ready_out = 1'h1;
   // One keystroke, held until the interpreter takes it; the line is scrambled after
   task automatic send(input logic [7:0] ch);
      int n = 0;
      @(negedge clk_in);
      rx_valid_out = 1'h1;
      rx_data_out = ch;
      while (rx_ready_in !== 1'h1 && n < 3000) begin
         @(negedge clk_in);
         n++;
      end
      @(negedge clk_in);
      rx_valid_out = 1'h0;
      rx_data_out = ~ch;
      if (n >= 3000) scint_top_bench.complete_run(1'h1);
   endtask
   // Printer accepts every cycle, or every other cycle when slow
   always @(negedge clk_in) tx_ready_out <= slow ? ~tx_ready_out : 1'h1;
   always @(posedge clk_in) if (tx_valid_in === 1'h1 && tx_ready_out) got.push_back(tx_data_in);
endmodule
`default_nettype wire

/* File: bench/scint_top_bench.sv */
// Self-checking bench for the service console interpreter
`timescale 1ns/100ps
`default_nettype none
module scint_top_bench;
   import scint_pkg::*;
   logic             core_clk_in = 1'h0;
   logic             rst_n_in = 1'h0;
   logic             rx_valid, rx_ready, tx_valid, tx_ready, cell_we, active;
   logic             mem_ack = 1'h0;
   logic             mem_present = 1'h0;
   logic             enter = 1'h0;
   logic [7:0]       rx_data, tx_data;
   logic [3:0]       cell_sel;
   logic [15:0]      cell_wdata, cell_rdata;
   logic [15:0]      mem_rdata = 16'h0000;
   logic [16:0]      enter_pc = 17'h00000;
   logic [16:0]      last_addr = 17'h00000;
   logic [4:0]       seen = 5'h00;
   logic [15:0]      mem [0:63];
   logic [15:0]      cells [0:15];
   scint_mem_t       mem_o;
   scint_ctl_t       ctl_o, ctl_cap;
   int               miscompares = 0;
   int               n_tests = 0;
   wire logic [4:0]  pulses = {ctl_o.io_reset, ctl_o.map_clear, ctl_o.run_start,
                               ctl_o.load_start, ctl_o.boot_start};
   always #10 core_clk_in = ~core_clk_in;
   scint_top dut_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .rx_valid_in(rx_valid),
      .rx_data_in(rx_data), .rx_ready_out(rx_ready), .tx_valid_out(tx_valid),
      .tx_data_out(tx_data), .tx_ready_in(tx_ready), .mem_out(mem_o), .mem_ack_in(mem_ack),
      .mem_present_in(mem_present), .mem_rdata_in(mem_rdata), .cell_sel_out(cell_sel),
      .cell_we_out(cell_we), .cell_wdata_out(cell_wdata), .cell_rdata_in(cell_rdata),
      .enter_in(enter), .enter_pc_in(enter_pc), .ctl_out(ctl_o), .console_active_out(active));
   scint_term term_u (.clk_in(core_clk_in), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
      .rx_ready_in(rx_ready), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
      .tx_ready_out(tx_ready));
   // Memory answers one cycle after a request; only the low 64 words exist
   always @(negedge core_clk_in) begin
      mem_ack <= mem_o.req && !mem_ack;
      mem_present <= mem_o.addr < 17'h00040;
      mem_rdata <= (mem_o.addr < 17'h00040) ? mem[mem_o.addr[5:0]] : ~mem_rdata;
      if (mem_o.req && !mem_ack) last_addr <= mem_o.addr;
      if (mem_o.req && !mem_ack && mem_o.we && mem_o.addr < 17'h00040)
         mem[mem_o.addr[5:0]] <= mem_o.wdata;
   end
   // Internal cells and a record of control pulses
   assign cell_rdata = cells[cell_sel];
   always @(negedge core_clk_in) if (cell_we) cells[cell_sel] <= cell_wdata;
   always @(posedge core_clk_in) if (|pulses) begin
      seen <= seen | pulses;
      ctl_cap <= ctl_o;
   end
   function automatic string ov(input logic [15:0] v);
      return {$sformatf("%06o", v), " "};
   endfunction
   task automatic check(input string what, input logic [31:0] got_v, input logic [31:0] exp);
      n_tests++;
      if (got_v !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got_v);
      end
   endtask
   task automatic complete_run(input bit timed_out);
      if (timed_out) miscompares++;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic say(input string s);
      foreach (s[i]) term_u.send(s[i]);
   endtask
   // Waits for idle with the printer drained, then compares the end of the printout
   task automatic tail(input string what, input string exp);
      int n = 0;
      int b;
      while ((rx_ready !== 1'h1 || tx_valid !== 1'h0) && n < 3000) begin
         @(negedge core_clk_in);
         n++;
      end
      if (n >= 3000) complete_run(1'h1);
      b = term_u.got.size() - exp.len();
      if (b < 0) check(what, 32'h0, 32'h1);
      else foreach (exp[i]) check(what, term_u.got[b + i], exp[i]);
      term_u.got.delete();
   endtask
   // Types a command that leaves the console, then checks the pulses seen
   task automatic leave(input string s, input logic [4:0] exp);
      int n = 0;
      seen = 5'h00;
      say(s);
      while (active !== 1'h0 && n < 3000) begin
         @(negedge core_clk_in);
         n++;
      end
      if (n >= 3000) complete_run(1'h1);
      @(negedge core_clk_in);
      check({s, " pulses"}, seen, exp);
   endtask
   task automatic reenter(input logic [16:0] pc);
      @(negedge core_clk_in);
      enter_pc = pc;
      enter = 1'h1;
      @(negedge core_clk_in);
      enter = 1'h0;
      tail("entry", {"\r\n", $sformatf("%06o", pc[15:0]), "\r\n!"});
   endtask
   task automatic t_mem();
      term_u.slow = 1'h1;
      say("000005/");
      tail("open 5", ov(mem[5]));
      check("addr 5", last_addr, 17'h00005);
      say("7654\r");
      tail("next after write", ov(mem[6]));
      check("write 5", mem[5], 16'h0FAC);
      say("+");
      tail("step", ov(mem[7]));
      say(".\r");
      tail("closed", "\r\n!");
      check("no access", last_addr, 17'h00007);
      say("377777/");
      tail("absent", "177777 ");
      say("0\n377777/");
      tail("absent again", "177777 ");
      check("top addr", last_addr, 17'h1FFFF);
      say(".");
      term_u.slow = 1'h0;
      $display("memory cells done");
   endtask
   task automatic t_cell();
      cells[4] = 16'h0020;
      cells[5] = 16'h000A;
      say("4A");
      tail("cell 4", ov(16'h0020));
      check("sel 4", cell_sel, 4'h4);
      say("+");
      tail("cell 5", ov(16'h000A));
      say("@");
      tail("indirect", ov(mem[10]));
      check("indirect addr", last_addr, 17'h0000A);
      say(".6A1357\n");
      tail("cell written", "");
      check("cell write", cells[6], 16'h02EF);
      $display("internal cells done");
   endtask
   task automatic t_err();
      string s = "Ka9Z";
      say("12");
      foreach (s[i]) begin
         say(s.substr(i, i));
         tail("error reply", "?\r\n!");
      end
      seen = 5'h00;
      say("I");
      tail("reset prompt", "\r\n!");
      check("reset pulses", seen, 5'h18);
      $display("errors and reset done");
   endtask
   task automatic t_run();
      cells[4] = 16'h029C;
      leave("P", 5'h04);
      check("resume addr", ctl_cap.run_addr, 17'h0029C);
      reenter(17'h0043F);
      leave("4000R", 5'h1C);
      check("start addr", ctl_cap.run_addr, 17'h00800);
      reenter(17'h00800);
      leave("100027L", 5'h02);
      check("high load", {ctl_cap.load_dev, ctl_cap.load_high}, {16'h8017, 1'h1});
      reenter(17'h00000);
      leave("26L", 5'h02);
      check("low load", {ctl_cap.load_dev, ctl_cap.load_high}, {16'h0016, 1'h0});
      reenter(17'h00000);
      leave("F", 5'h01);
      reenter(17'h1FFFF);
      $display("execution commands done");
   endtask
   // Main sequence
   initial begin
      foreach (mem[i]) mem[i] = 16'(i * 16'h0403);
      foreach (cells[i]) cells[i] = 16'(i * 16'h0111);
      repeat (4) @(posedge core_clk_in);
      @(negedge core_clk_in);
      rst_n_in = 1'h1;
      tail("power-up entry", "\r\n000000\r\n!");
      check("active", active, 1'h1);
      t_mem();
      t_cell();
      t_err();
      t_run();
      complete_run(1'h0);
   end
endmodule
`default_nettype wire
